/* verif/testbench.sv */
// self-checking bench for the usb switch fault timer
`timescale 1ns/1ns
module testbench;
  reg        clk_sys = 1'b0;
  reg        rst = 1'b0;
  reg  [1:0] lvl = 2'h0;
  reg        oc = 1'b0, sh = 1'b0, unplug = 1'b0;
  wire       uv, ovt, ove, ocf, scf, det, gate_on, fast_off, in_d, out_d, flt_n;
  wire [7:0] ramp;
  integer    errors = 0, total_checks = 0, cyc = 0, k, t;
  reg  [3:0] rows [0:4];
  usft_analog_model usft_analog_model_i (.vin_lvl(lvl), .load_oc(oc), .load_short(sh),
    .unplug(unplug), .gate_on_ff(gate_on), .uv_ok_async(uv), .ov_trip_async(ovt),
    .ov_exit_async(ove), .overcurrent_flag_async(ocf), .sc_trip_async(scf), .detach_async(det));
  usft_switch_fault_timer #(.DISCH_CY(100), .OC_BLANK_CY(50), .HIC_ON_CY(60),
    .HIC_OFF_CY(200), .FLT_DGL_CY(60)) usft_switch_fault_timer_i (.clk_sys(clk_sys), .rst(rst),
    .uv_ok_async(uv), .ov_trip_async(ovt), .ov_exit_async(ove), .overcurrent_flag_async(ocf),
    .sc_trip_async(scf), .detach_async(det), .gate_on_ff(gate_on), .gate_ramp_ff(ramp),
    .gate_fast_off_ff(fast_off), .in_disch_ff(in_d), .out_disch_ff(out_d), .fault_n_ff(flt_n));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #2;
    end
  endtask
  task check(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  function sig(input integer s);
    sig = s == 0 ? gate_on : s == 1 ? fast_off : s == 2 ? ramp === 8'hFF : flt_n;
  endfunction
  task wait_for(input integer s, input v, input integer lim);
    begin
      t = 0;
      while (sig(s) !== v && t < lim) begin
        step(1);
        t = t + 1;
      end
      check(sig(s), v);
    end
  endtask
  initial begin
    rows = '{4'hF, 4'hB, 4'h5, 4'hF, 4'h5};
    #2;
    rst = 1'b1;
    step(5);
    check({gate_on, fast_off, in_d, out_d, flt_n, ramp[2:0]}, 8'h08);
    $display("test reset done");
    rst = 1'b0;
    lvl = 2'h1;
    step(2000);
    check(gate_on, 1'b0);
    wait_for(0, 1'b1, 800);
    check(ramp === 8'hFF, 1'b0);
    wait_for(2, 1'b1, 3000);
    $display("test startup done");
    for (k = 0; k < 5; k = k + 1) begin
      lvl = rows[k][3:2];
      step(6);
      check({in_d, gate_on}, rows[k][1:0]);
    end
    $display("test overvoltage done");
    unplug = 1'b1;
    step(6);
    check({in_d, out_d}, 2'h3);
    step(96);
    check({in_d, out_d}, 2'h3);
    step(2);
    check({in_d, out_d}, 2'h0);
    unplug = 1'b0;
    $display("test detach done");
    for (k = 0; k < 2; k = k + 1) begin
      oc = 1'b1;
      step(30);
      check(ramp, 8'hFF);
      oc = 1'b0;
      step(10);
      check({gate_on, flt_n}, 2'h3);
    end
    oc = 1'b1;
    step(45);
    check({gate_on, ramp}, 9'h1FF);
    wait_for(0, 1'b0, 100);
    check(flt_n, 1'b0);
    step(150);
    check(gate_on, 1'b0);
    wait_for(0, 1'b1, 100);
    wait_for(0, 1'b0, 100);
    oc = 1'b0;
    wait_for(0, 1'b1, 300);
    step(70);
    check(gate_on, 1'b1);
    wait_for(3, 1'b1, 200);
    $display("test overcurrent done");
    sh = 1'b1;
    wait_for(1, 1'b1, 6);
    wait_for(1, 1'b0, 2100);
    check(t > 1990 && t < 2010, 1'b1);
    wait_for(0, 1'b0, 20);
    check(fast_off, 1'b0);
    sh = 1'b0;
    wait_for(0, 1'b1, 2400);
    step(70);
    check(gate_on, 1'b1);
    lvl = 2'h0;
    step(8);
    check({gate_on, ramp}, 9'h000);
    $display("test short done");
    complete_run;
  end
endmodule

/* verif/usft_analog_model.sv */
// comparator and load model on the analog side of the switch
`timescale 1ns/1ns
module usft_analog_model (
  input  wire [1:0] vin_lvl,
  input  wire       load_oc,
  input  wire       load_short,
  input  wire       unplug,
  input  wire       gate_on_ff,
  output wire       uv_ok_async,
  output wire       ov_trip_async,
  output wire       ov_exit_async,
  output wire       overcurrent_flag_async,
  output wire       sc_trip_async,
  output wire       detach_async
);
  // level 0 below uv, 1 normal, 2 above exit, 3 above trip
  assign uv_ok_async = vin_lvl != 2'h0;
  assign ov_trip_async = vin_lvl == 2'h3;
  assign ov_exit_async = vin_lvl < 2'h2;
  // current flows only while the fet conducts
  assign overcurrent_flag_async = load_oc && gate_on_ff;
  assign sc_trip_async = load_short && gate_on_ff;
  assign detach_async = unplug;
endmodule

/* verif/usft_props.sv */
// assertions on the ports of the usb switch fault timer
`timescale 1ns/1ns
module usft_props #(
  parameter DISCH_CY = 100, OC_BLANK_CY = 50, HIC_ON_CY = 60, HIC_OFF_CY = 200, FLT_DGL_CY = 60
) (
  input wire       clk_sys,
  input wire       rst,
  input wire       uv_ok_async,
  input wire       ov_trip_async,
  input wire       ov_exit_async,
  input wire       overcurrent_flag_async,
  input wire       sc_trip_async,
  input wire       gate_on_ff,
  input wire [7:0] gate_ramp_ff,
  input wire       gate_fast_off_ff,
  input wire       in_disch_ff,
  input wire       out_disch_ff,
  input wire       fault_n_ff
);
  reg [11:0] off_cnt_ff;
  // length of the current fast-off hold
  always @(posedge clk_sys or posedge rst)
    if (rst) off_cnt_ff <= 12'h000;
    else off_cnt_ff <= gate_fast_off_ff ? off_cnt_ff + 12'h001 : 12'h000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reset_quiet_a: assert property (disable iff (1'b0) rst |-> !gate_on_ff && fault_n_ff
    && gate_ramp_ff == 8'h00 && !in_disch_ff && !out_disch_ff) else $error("reset outputs");
  off_excl_a: assert property (!(gate_fast_off_ff && gate_on_ff))
    else $error("gate on during fast off");
  sc_fast_a: assert property ($rose(sc_trip_async) && $past(gate_on_ff) && gate_on_ff
    && gate_ramp_ff == 8'hFF |-> ##[1:4] gate_fast_off_ff) else $error("no fast off");
  ov_exit_a: assert property ($rose(ov_exit_async) && !ov_trip_async && !out_disch_ff
    |-> ##[1:4] (!in_disch_ff || out_disch_ff)) else $error("input discharge kept after exit");
  off_hold_a: assert property ($fell(gate_fast_off_ff) |-> off_cnt_ff > 12'd1990
    && off_cnt_ff < 12'd2010) else $error("fast off hold length");
  ov_disch_a: assert property ($rose(ov_trip_async) && gate_on_ff
    |-> ##[1:4] (in_disch_ff && gate_on_ff)) else $error("no input discharge");
  det_pair_a: assert property ($rose(out_disch_ff) |-> in_disch_ff [*8])
    else $error("discharges not paired");
  oc_blank_a: assert property ($rose(overcurrent_flag_async) && gate_ramp_ff == 8'hFF
    |-> (gate_on_ff && gate_ramp_ff == 8'hFF) [*8]) else $error("switch cut in blanking");
  flt_dgl_a: assert property ($rose(overcurrent_flag_async) && fault_n_ff && !ov_trip_async
    && !in_disch_ff |-> fault_n_ff [*8]) else $error("fault without deglitch");
  uv_off_a: assert property (!uv_ok_async [*4] |-> !gate_on_ff && gate_ramp_ff == 8'h00)
    else $error("gate on without input");
endmodule
bind usft_switch_fault_timer usft_props #(.DISCH_CY(DISCH_CY), .OC_BLANK_CY(OC_BLANK_CY),
  .HIC_ON_CY(HIC_ON_CY), .HIC_OFF_CY(HIC_OFF_CY), .FLT_DGL_CY(FLT_DGL_CY)) usft_props_i (
  .clk_sys(clk_sys), .rst(rst), .uv_ok_async(uv_ok_async), .ov_trip_async(ov_trip_async),
  .ov_exit_async(ov_exit_async), .overcurrent_flag_async(overcurrent_flag_async),
  .sc_trip_async(sc_trip_async), .gate_on_ff(gate_on_ff), .gate_ramp_ff(gate_ramp_ff),
  .gate_fast_off_ff(gate_fast_off_ff), .in_disch_ff(in_disch_ff), .out_disch_ff(out_disch_ff),
  .fault_n_ff(fault_n_ff));

/* verilog/usft_map.vh */
// constants for the usb switch fault timer
`ifndef USFT_MAP_VH
`define USFT_MAP_VH
`define USFT_CLK_HZ       25000000
`define USFT_START_DLY_US 100
`define USFT_START_DLY_CY 2500
`define USFT_DISCH_MS     30
`define USFT_DISCH_CY     750000
`define USFT_OC_BLANK_US  1700
`define USFT_OC_BLANK_CY  42500
`define USFT_HIC_ON_US    2000
`define USFT_HIC_ON_CY    50000
`define USFT_HIC_OFF_MS   2000
`define USFT_HIC_OFF_CY   50000000
`define USFT_SC_OFF_US    80
`define USFT_SC_OFF_CY    2000
`define USFT_SC_CHK_CY    8
`define USFT_FLT_DGL_US   2000
`define USFT_FLT_DGL_CY   50000
`define USFT_RAMP_STEPS   8'hFF
`define USFT_RAMP_DIV     16'h0009
`endif

/* verilog/usft_switch_fault_timer.v */
// control and fault timing for a usb port current-limit switch
`timescale 1ns/1ns
`include "usft_map.vh"
module usft_switch_fault_timer #(
  parameter DISCH_CY   = `USFT_DISCH_CY,
  parameter OC_BLANK_CY = `USFT_OC_BLANK_CY,
  parameter HIC_ON_CY  = `USFT_HIC_ON_CY,
  parameter HIC_OFF_CY = `USFT_HIC_OFF_CY,
  parameter FLT_DGL_CY = `USFT_FLT_DGL_CY
) (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       uv_ok_async,
  input  wire       ov_trip_async,
  input  wire       ov_exit_async,
  input  wire       overcurrent_flag_async,
  input  wire       sc_trip_async,
  input  wire       detach_async,
  output reg        gate_on_ff,
  output reg  [7:0] gate_ramp_ff,
  output reg        gate_fast_off_ff,
  output reg        in_disch_ff,
  output reg        out_disch_ff,
  output reg        fault_n_ff
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam [6:0] ST_OFF   = 7'h01;
  localparam [6:0] ST_DLY   = 7'h02;
  localparam [6:0] ST_RAMP  = 7'h04;
  localparam [6:0] ST_NORM  = 7'h08;
  localparam [6:0] ST_HON   = 7'h10;
  localparam [6:0] ST_HOFF  = 7'h20;
  localparam [6:0] ST_SCOFF = 7'h40;

  // ****************************************************************
  // timer limits
  // ****************************************************************
  localparam [25:0] LIM_START = 26'd`USFT_START_DLY_CY;
  localparam [25:0] LIM_BLANK = OC_BLANK_CY[25:0];
  localparam [25:0] LIM_HON   = HIC_ON_CY[25:0];
  localparam [25:0] LIM_HOFF  = HIC_OFF_CY[25:0];
  localparam [25:0] LIM_SCOFF = 26'd`USFT_SC_OFF_CY;
  localparam [25:0] LIM_SCCHK = 26'd`USFT_SC_CHK_CY;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  reg  [5:0] sync1_ff;
  reg  [5:0] sync2_ff;
  reg        detach_d_ff;
  wire       uv_ok   = sync2_ff[0];
  wire       ov_trip = sync2_ff[1];
  wire       ov_exit = sync2_ff[2];
  wire       oc      = sync2_ff[3];
  wire       sc      = sync2_ff[4];
  wire       detach  = sync2_ff[5];
  wire       detach_rise = detach & ~detach_d_ff;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_ff    <= 6'h00;
      sync2_ff    <= 6'h00;
      detach_d_ff <= 1'b0;
    end else begin
      sync1_ff    <= {detach_async, sc_trip_async, overcurrent_flag_async,
                      ov_exit_async, ov_trip_async, uv_ok_async};
      sync2_ff    <= sync1_ff;
      detach_d_ff <= detach;
    end
  end

  function done;
    input [25:0] cnt;
    input [25:0] lim;
    begin
      done = (cnt >= lim - 26'h0000001);
    end
  endfunction

  // states in which the fet is commanded on
  function is_on_state;
    input [6:0] st;
    begin
      is_on_state = (st == ST_RAMP) || (st == ST_NORM) || (st == ST_HON);
    end
  endfunction

  // states that count as an over-current fault
  function is_fault_state;
    input [6:0] st;
    begin
      is_fault_state = (st == ST_HON) || (st == ST_HOFF) || (st == ST_SCOFF);
    end
  endfunction

  // ****************************************************************
  // main sequencer
  // ****************************************************************
  reg  [6:0]  state_ff;
  reg  [6:0]  nxt_state;
  reg  [25:0] tmr_ff;
  reg  [25:0] nxt_tmr;
  reg  [15:0] div_ff;
  reg  [7:0]  nxt_ramp;
  reg  [15:0] nxt_div;
  reg         sc_retry_ff;
  reg         nxt_sc_retry;

  always @* begin
    nxt_state    = state_ff;
    nxt_tmr      = tmr_ff + 26'h0000001;
    nxt_ramp     = gate_ramp_ff;
    nxt_div      = div_ff;
    nxt_sc_retry = sc_retry_ff;
    case (state_ff)
      ST_OFF: begin
        nxt_ramp = 8'h00;
        nxt_tmr  = 26'h0000000;
        if (uv_ok) begin
          nxt_state = ST_DLY;
        end
      end
      ST_DLY: begin
        if (done(tmr_ff, LIM_START)) begin
          nxt_state = ST_RAMP;
          nxt_tmr   = 26'h0000000;
          nxt_div   = 16'h0000;
        end
      end
      ST_RAMP: begin
        // slew-limited gate ramp
        // one step every RAMP_DIV+1 cycles up to full drive
        nxt_tmr = 26'h0000000;
        if (div_ff == `USFT_RAMP_DIV) begin
          nxt_div = 16'h0000;
          if (gate_ramp_ff == `USFT_RAMP_STEPS) begin
            nxt_state = ST_NORM;
          end else begin
            nxt_ramp = gate_ramp_ff + 8'h01;
          end
        end else begin
          nxt_div = div_ff + 16'h0001;
        end
      end
      ST_NORM: begin
        nxt_ramp = `USFT_RAMP_STEPS;
        if (sc_retry_ff) begin
          // watch window covers synchroniser latency after turn-on
          if (sc) begin
            // short still there after retry
            nxt_state    = ST_HOFF;
            nxt_sc_retry = 1'b0;
            nxt_tmr      = 26'h0000000;
          end else if (done(tmr_ff, LIM_SCCHK)) begin
            nxt_sc_retry = 1'b0;
            nxt_tmr      = 26'h0000000;
          end
        end else if (oc) begin
          // blanking, switch stays fully on
          if (done(tmr_ff, LIM_BLANK)) begin
            nxt_state = ST_HON;
            nxt_tmr   = 26'h0000000;
          end
        end else begin
          nxt_tmr = 26'h0000000;
        end
      end
      ST_HON: begin
        nxt_ramp = `USFT_RAMP_STEPS;
        if (done(tmr_ff, LIM_HON)) begin
          nxt_tmr = 26'h0000000;
          nxt_state = (oc || sc) ? ST_HOFF : ST_NORM;
        end
      end
      ST_HOFF: begin
        nxt_ramp = 8'h00;
        if (done(tmr_ff, LIM_HOFF)) begin
          nxt_state = ST_HON;
          nxt_tmr   = 26'h0000000;
        end
      end
      ST_SCOFF: begin
        nxt_ramp = 8'h00;
        if (done(tmr_ff, LIM_SCOFF)) begin
          nxt_state    = ST_NORM;
          nxt_sc_retry = 1'b1;
          nxt_tmr      = 26'h0000000;
        end
      end
      default: begin
        nxt_state = ST_OFF;
        nxt_tmr   = 26'h0000000;
      end
    endcase
    // fast path acts in ramp and normal only
    // hiccup and the retry window handle a short on their own
    if (sc && (state_ff == ST_NORM || state_ff == ST_RAMP) && !sc_retry_ff) begin
      nxt_state = ST_SCOFF;
      nxt_tmr   = 26'h0000000;
      nxt_ramp  = 8'h00;
    end
    if (!uv_ok) begin
      nxt_state    = ST_OFF;
      nxt_tmr      = 26'h0000000;
      nxt_ramp     = 8'h00;
      nxt_sc_retry = 1'b0;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff         <= ST_OFF;
      tmr_ff           <= 26'h0000000;
      div_ff           <= 16'h0000;
      sc_retry_ff      <= 1'b0;
    end else begin
      state_ff         <= nxt_state;
      tmr_ff           <= nxt_tmr;
      div_ff           <= nxt_div;
      sc_retry_ff      <= nxt_sc_retry;
    end
  end

  // ****************************************************************
  // gate drive outputs
  // ****************************************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_ramp_ff     <= 8'h00;
      gate_on_ff       <= 1'b0;
      gate_fast_off_ff <= 1'b0;
    end else begin
      gate_ramp_ff     <= nxt_ramp;
      gate_on_ff       <= is_on_state(nxt_state);
      gate_fast_off_ff <= (nxt_state == ST_SCOFF);
    end
  end

  // ****************************************************************
  // discharge control
  // ****************************************************************
  reg        ov_ff;
  reg [19:0] dis_ff;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ov_ff        <= 1'b0;
      dis_ff       <= 20'h00000;
      in_disch_ff  <= 1'b0;
      out_disch_ff <= 1'b0;
    end else begin
      // trip wins over exit
      if (ov_trip) begin
        ov_ff <= 1'b1;
      end else if (ov_exit) begin
        ov_ff <= 1'b0;
      end
      // window lasts DISCH_CY cycles from the detach edge
      if (detach_rise) begin
        dis_ff <= DISCH_CY[19:0];
      end else if (dis_ff != 20'h00000) begin
        dis_ff <= dis_ff - 20'h00001;
      end
      in_disch_ff  <= ov_trip | (ov_ff & ~ov_exit) | detach_rise |
                      (dis_ff > 20'h00001);
      out_disch_ff <= detach_rise | (dis_ff > 20'h00001);
    end
  end

  // ****************************************************************
  // fault indication
  // ****************************************************************
  reg [15:0] dgl_ff;
  wire       oc_fault = oc | is_fault_state(state_ff);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dgl_ff     <= 16'h0000;
      fault_n_ff <= 1'b1;
    end else begin
      // count saturates so the fault holds while it lasts
      if (!oc_fault) begin
        dgl_ff <= 16'h0000;
      end else if (dgl_ff != FLT_DGL_CY[15:0]) begin
        dgl_ff <= dgl_ff + 16'h0001;
      end
      fault_n_ff <= ~(ov_ff | ov_trip | (oc_fault && dgl_ff == FLT_DGL_CY[15:0]));
    end
  end
endmodule
